// *** mscc_defines.vh ***
// Contract
// R1 - Mode strap high at start-up selects fuse-page mode, low selects bus mode.
// R2 - Mode is latched at power-up; later strap changes do not alter it.
// R3 - Fuse-page mode loads page {select bit1, select bit0} into active registers.
// R4 - In fuse-page mode bus pins are page selects, bus off, address strap ignored.
// R5 - Changing mode needs a strap change followed by a full power cycle.
// R6 - Select change then strap high switches page; no strap within 350 us enters bus mode.
// R7 - Select change causes internal power cycle and reload, stable within 1.5 ms.
// R8 - Bus mode starts from fuse page 0; fuse-page mode from the selected page.
// R9 - Host rewrites active registers after every power cycle; writes are not kept.
// R10 - power_down_bit R10[1] set enters low power, cleared leaves it.
// R11 - idle_entry_select R10[4] at 0 with outputs disabled enters low power.
// R12 - Host enters low power before divider, spread or format changes.
// R13 - page0_reload_inhibit R10[2] set stops page 0 reload on low-power exit.
// R14 - strap_resample_inhibit R10[3] set stops strap and select resampling on exit.
// R15 - Exit with both inhibits set leaves register contents unchanged.
// R16 - Exit with reload allowed and resample inhibited copies fuse page 0.
// R17 - Exit with resampling and mode strap high enters fuse mode, loads selected page.
// R18 - Fuse array is fixed; fuse_programmed_flag R0[0] always reads 1.
// R19 - Only spread, pair enables, pair formats, spread setting differ between pages.
// R20 - Bus address upper five bits come from bus_address_field R12[14:10].
// R21 - Strap low/high/data/clock gives address 0x68/0x69/0x6A/0x6B.
// R22 - address_low_bits_from_pin R12[15] at 0 takes whole address from R12[14:8].
// R23 - Host sets power_down_bit, writes registers, then clears power_down_bit.
`ifndef MSCC_DEFINES_VH
`define MSCC_DEFINES_VH

`define MSCC_DW              16
`define MSCC_AW              8
`define MSCC_NREG            16
`define MSCC_IDX_W           4
`define MSCC_IDX_LAST        4'hF

// Register indices
`define MSCC_R_ID            4'h0
`define MSCC_R_SPREAD        4'h4
`define MSCC_R_SPREAD_CFG    4'h9
`define MSCC_R_CTRL          4'hA
`define MSCC_R_OUTPUT        4'hB
`define MSCC_R_ADDR          4'hC

// Field positions
`define MSCC_B_FUSE_PROG     0
`define MSCC_B_SPREAD_EN     0
`define MSCC_F_SPREAD_SET    11:9
`define MSCC_B_PWR_DOWN      1
`define MSCC_B_RELOAD_INH    2
`define MSCC_B_RESAMPLE_INH  3
`define MSCC_B_IDLE_SEL      4
`define MSCC_B_AB_EN         0
`define MSCC_B_CD_EN         1
`define MSCC_F_AB_FMT        3:2
`define MSCC_F_CD_FMT        5:4
`define MSCC_B_ADDR_PIN      15
`define MSCC_F_ADDR_HI       14:10
`define MSCC_F_ADDR_LO       9:8

// Fuse contents common to all pages
`define MSCC_FUSE_R0         16'h0001
`define MSCC_FUSE_R12        16'hE800
`define MSCC_FUSE_COMMON     16'h0000

// Per-page fields, one bit or field per page, page 0 lowest
`define MSCC_PG_SPREAD_EN    4'hA
`define MSCC_PG_AB_EN        4'hF
`define MSCC_PG_CD_EN        4'hF
`define MSCC_PG_AB_FMT       8'h00
`define MSCC_PG_CD_FMT       8'h00
`define MSCC_PG_SPREAD_SET   12'h4C8

`define MSCC_PAGE0           2'h0
`define MSCC_WORD0           4'h0

// Timing
`define MSCC_CLK_PERIOD_NS   4
`define MSCC_SWITCH_WIN_NS   350000
// 350 us window at a 4 ns clock
`define MSCC_SWITCH_WIN_CYC  17'h155CC
`define MSCC_SWITCH_CNT_W    17

`endif

// *** mscc_fuse_rom.v ***
`timescale 1ns/100ps
`include "mscc_defines.vh"
module mscc_fuse_rom
(
    input  wire [1:0]             page,
    input  wire [`MSCC_IDX_W-1:0] word,
    output reg  [`MSCC_DW-1:0]    data
);

localparam [3:0]  PG_SPREAD_EN  = `MSCC_PG_SPREAD_EN;
localparam [3:0]  PG_AB_EN      = `MSCC_PG_AB_EN;
localparam [3:0]  PG_CD_EN      = `MSCC_PG_CD_EN;
localparam [7:0]  PG_AB_FMT     = `MSCC_PG_AB_FMT;
localparam [7:0]  PG_CD_FMT     = `MSCC_PG_CD_FMT;
localparam [11:0] PG_SPREAD_SET = `MSCC_PG_SPREAD_SET;

wire [3:0]  shift3;
wire [2:0]  shift2;
wire [11:0] spread_set_sh;
wire [7:0]  ab_fmt_sh;
wire [7:0]  cd_fmt_sh;

// Bit offsets of the page's field: three or two bits per page
assign shift3        = {1'b0, page, 1'b0} + {2'b00, page};
assign shift2        = {page, 1'b0};
assign spread_set_sh = PG_SPREAD_SET >> shift3;
assign ab_fmt_sh     = PG_AB_FMT >> shift2;
assign cd_fmt_sh     = PG_CD_FMT >> shift2;

// ----------------------------------------
// Fixed fuse pages
// ----------------------------------------
always @*
begin
    if (word == `MSCC_R_ID)
        data = `MSCC_FUSE_R0; // R18
    else if (word == `MSCC_R_ADDR)
        data = `MSCC_FUSE_R12;
    else
        data = `MSCC_FUSE_COMMON;
    // Only these fields vary between pages
    if (word == `MSCC_R_SPREAD)
        data[`MSCC_B_SPREAD_EN] = PG_SPREAD_EN[page]; // R19
    if (word == `MSCC_R_SPREAD_CFG)
        data[`MSCC_F_SPREAD_SET] = spread_set_sh[2:0]; // R19
    if (word == `MSCC_R_OUTPUT)
    begin
        data[`MSCC_B_AB_EN]  = PG_AB_EN[page]; // R19
        data[`MSCC_B_CD_EN]  = PG_CD_EN[page];
        data[`MSCC_F_AB_FMT] = ab_fmt_sh[1:0];
        data[`MSCC_F_CD_FMT] = cd_fmt_sh[1:0];
    end
end

endmodule

// *** mscc_config_ctrl.v ***
`timescale 1ns/100ps
`include "mscc_defines.vh"
module mscc_config_ctrl
#(
    parameter [`MSCC_SWITCH_CNT_W-1:0] SWITCH_WIN_CYC = `MSCC_SWITCH_WIN_CYC
)
(
    input  wire                   mclk,
    input  wire                   srst,
    input  wire                   mode_strap_in,
    input  wire                   page_select_bit0,
    input  wire                   page_select_bit1,
    input  wire [1:0]             addr_strap_in,
    input  wire [`MSCC_AW-1:0]    reg_addr,
    input  wire [`MSCC_DW-1:0]    reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [`MSCC_DW-1:0]    reg_rdata,
    output reg                    fuse_mode,
    output reg                    bus_enable,
    output reg  [6:0]             bus_target_addr,
    output reg  [1:0]             active_page,
    output reg                    low_power,
    output reg                    config_stable,
    output reg                    spread_enable,
    output reg  [2:0]             spread_setting,
    output reg                    pair_ab_enable,
    output reg                    pair_cd_enable,
    output reg  [1:0]             pair_ab_format,
    output reg  [1:0]             pair_cd_format
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [4:0] ST_POR    = 5'h01;
localparam [4:0] ST_LOAD   = 5'h02;
localparam [4:0] ST_RUN    = 5'h04;
localparam [4:0] ST_LOWPWR = 5'h08;
localparam [4:0] ST_SWITCH = 5'h10;

// ----------------------------------------
// Storage
// ----------------------------------------
reg  [`MSCC_DW-1:0]           regs_reg [0:`MSCC_NREG-1];
reg  [4:0]                    state_reg;
reg                           mode_reg;
reg  [1:0]                    page_reg;
reg  [1:0]                    addr_strap_reg;
reg  [`MSCC_IDX_W-1:0]        word_reg;
reg  [`MSCC_SWITCH_CNT_W-1:0] win_cnt_reg;
wire [`MSCC_DW-1:0]           rom_data;
wire [1:0]                    sel_pins;
wire                          addr_hit;
wire [`MSCC_IDX_W-1:0]        idx;
wire [`MSCC_DW-1:0]           ctrl_word;
wire [`MSCC_DW-1:0]           out_word;
wire                          pwr_down;
wire                          idle_sel;
wire                          reload_inh;
wire                          resample_inh;
wire                          outs_off;
wire                          lp_req;
wire                          host_wr;
wire                          settled;
integer                       i;

assign sel_pins     = {page_select_bit1, page_select_bit0}; // R3
assign addr_hit     = (reg_addr[`MSCC_AW-1:`MSCC_IDX_W] == {(`MSCC_AW-`MSCC_IDX_W){1'b0}});
assign idx          = reg_addr[`MSCC_IDX_W-1:0];
assign ctrl_word    = regs_reg[`MSCC_R_CTRL];
assign out_word     = regs_reg[`MSCC_R_OUTPUT];
assign pwr_down     = ctrl_word[`MSCC_B_PWR_DOWN];
assign idle_sel     = ctrl_word[`MSCC_B_IDLE_SEL];
assign reload_inh   = ctrl_word[`MSCC_B_RELOAD_INH];
assign resample_inh = ctrl_word[`MSCC_B_RESAMPLE_INH];
assign outs_off     = ~out_word[`MSCC_B_AB_EN] & ~out_word[`MSCC_B_CD_EN];
assign lp_req       = pwr_down | (~idle_sel & outs_off); // R10 R11
// Host writes registers only in bus mode and outside a load
assign settled      = (state_reg == ST_RUN) | (state_reg == ST_LOWPWR);
assign host_wr      = reg_wr & addr_hit & ~mode_reg & settled; // R4

mscc_fuse_rom u_rom
(
    .page (page_reg),
    .word (word_reg),
    .data (rom_data)
);

// ----------------------------------------
// Configuration sequencer
// ----------------------------------------
always @(posedge mclk)
begin
    if (srst)
    begin
        state_reg      <= ST_POR;
        mode_reg       <= 1'b0;
        page_reg       <= `MSCC_PAGE0;
        addr_strap_reg <= 2'h0;
        word_reg       <= `MSCC_WORD0;
        win_cnt_reg    <= {`MSCC_SWITCH_CNT_W{1'b0}};
        for (i = 0; i < `MSCC_NREG; i = i + 1)
            regs_reg[i] <= {`MSCC_DW{1'b0}};
    end
    else
    begin
        case (state_reg)
            ST_POR:
            begin
                // Straps caught once after power-up release
                mode_reg       <= mode_strap_in; // R1 R2 R5
                addr_strap_reg <= addr_strap_in;
                page_reg       <= mode_strap_in ? sel_pins : `MSCC_PAGE0; // R8
                word_reg       <= `MSCC_WORD0;
                state_reg      <= ST_LOAD;
            end
            ST_LOAD:
            begin
                regs_reg[word_reg] <= rom_data; // R3 R8
                word_reg           <= word_reg + 4'h1;
                if (word_reg == `MSCC_IDX_LAST)
                    state_reg <= ST_RUN;
            end
            ST_RUN:
            begin
                if (host_wr)
                begin
                    regs_reg[idx] <= reg_wdata;
                    if (idx == `MSCC_R_ID)
                        regs_reg[idx][`MSCC_B_FUSE_PROG] <= 1'b1; // R18
                end
                if (lp_req)
                    state_reg <= ST_LOWPWR; // R10 R11
                else if (mode_reg && (sel_pins != page_reg))
                begin
                    win_cnt_reg <= {`MSCC_SWITCH_CNT_W{1'b0}};
                    state_reg   <= ST_SWITCH; // R6
                end
            end
            ST_SWITCH:
            begin
                win_cnt_reg <= win_cnt_reg + 1'b1;
                word_reg    <= `MSCC_WORD0;
                if (mode_strap_in)
                begin
                    page_reg  <= sel_pins; // R6 R7
                    state_reg <= ST_LOAD;
                end
                else if (win_cnt_reg == SWITCH_WIN_CYC - 1'b1)
                begin
                    mode_reg  <= 1'b0; // R6
                    page_reg  <= `MSCC_PAGE0;
                    state_reg <= ST_LOAD;
                end
            end
            ST_LOWPWR:
            begin
                if (host_wr)
                begin
                    regs_reg[idx] <= reg_wdata;
                    if (idx == `MSCC_R_ID)
                        regs_reg[idx][`MSCC_B_FUSE_PROG] <= 1'b1; // R18
                end
                word_reg <= `MSCC_WORD0;
                if (!lp_req)
                begin
                    if (!resample_inh)
                    begin
                        // Pins taken again on leaving low power
                        mode_reg       <= mode_strap_in; // R14
                        addr_strap_reg <= addr_strap_in;
                        if (mode_strap_in)
                        begin
                            page_reg  <= sel_pins; // R17
                            state_reg <= ST_LOAD;
                        end
                        else if (!reload_inh)
                        begin
                            page_reg  <= `MSCC_PAGE0; // R13
                            state_reg <= ST_LOAD;
                        end
                        else
                            state_reg <= ST_RUN;
                    end
                    else if (!reload_inh)
                    begin
                        page_reg  <= `MSCC_PAGE0; // R16
                        state_reg <= ST_LOAD;
                    end
                    else
                        state_reg <= ST_RUN; // R15
                end
            end
            default:
                state_reg <= ST_POR;
        endcase
    end
end

// ----------------------------------------
// Register read port
// ----------------------------------------
always @(posedge mclk)
begin
    if (srst)
        reg_rdata <= {`MSCC_DW{1'b0}};
    else if (reg_rd && addr_hit && !mode_reg) // R4
        reg_rdata <= regs_reg[idx];
    else
        reg_rdata <= {`MSCC_DW{1'b0}};
end

// ----------------------------------------
// Status and configuration outputs
// ----------------------------------------
always @(posedge mclk)
begin
    if (srst)
    begin
        fuse_mode       <= 1'b0;
        bus_enable      <= 1'b0;
        bus_target_addr <= 7'h00;
        active_page     <= 2'h0;
        low_power       <= 1'b0;
        config_stable   <= 1'b0;
        spread_enable   <= 1'b0;
        spread_setting  <= 3'h0;
        pair_ab_enable  <= 1'b0;
        pair_cd_enable  <= 1'b0;
        pair_ab_format  <= 2'h0;
        pair_cd_format  <= 2'h0;
    end
    else
    begin
        fuse_mode     <= mode_reg;
        bus_enable    <= ~mode_reg & settled; // R4
        active_page   <= page_reg;
        low_power     <= (state_reg == ST_LOWPWR);
        config_stable <= settled; // R7
        if (mode_reg)
            bus_target_addr <= 7'h00; // R4
        else if (regs_reg[`MSCC_R_ADDR][`MSCC_B_ADDR_PIN])
            bus_target_addr <= {regs_reg[`MSCC_R_ADDR][`MSCC_F_ADDR_HI], addr_strap_reg}; // R20 R21
        else
            bus_target_addr <= {regs_reg[`MSCC_R_ADDR][`MSCC_F_ADDR_HI],
                                regs_reg[`MSCC_R_ADDR][`MSCC_F_ADDR_LO]}; // R22
        spread_enable  <= regs_reg[`MSCC_R_SPREAD][`MSCC_B_SPREAD_EN];
        spread_setting <= regs_reg[`MSCC_R_SPREAD_CFG][`MSCC_F_SPREAD_SET];
        pair_ab_enable <= out_word[`MSCC_B_AB_EN];
        pair_cd_enable <= out_word[`MSCC_B_CD_EN];
        pair_ab_format <= out_word[`MSCC_F_AB_FMT];
        pair_cd_format <= out_word[`MSCC_F_CD_FMT];
    end
end

endmodule

// *** mscc_config_ctrl_asserts.sv ***
`timescale 1ns/100ps
module mscc_config_ctrl_asserts
#(
    parameter [16:0] SWITCH_WIN_CYC = 17'h155CC
)
(
    input wire        mclk,
    input wire        srst,
    input wire        mode_strap_in,
    input wire [7:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        fuse_mode,
    input wire        bus_enable,
    input wire [6:0]  bus_target_addr,
    input wire [1:0]  active_page,
    input wire        low_power,
    input wire        config_stable,
    input wire        spread_enable,
    input wire [2:0]  spread_setting
);
// ------------------------------------------------------------
// Cycles spent unsettled
// ------------------------------------------------------------
reg [17:0] unstable_cnt_reg;
always @(posedge mclk)
begin
    if (srst || config_stable)
        unstable_cnt_reg <= 18'h0;
    else
        unstable_cnt_reg <= unstable_cnt_reg + 18'h1;
end
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
default clocking cb @(posedge mclk); endclocking
default disable iff (srst);
sequence s_boot;
    $fell(srst) ##22 1'b1;
endsequence
sequence s_pdn_set;
    reg_wr && reg_addr == 8'h0A && reg_wdata[1] && config_stable && !low_power && !fuse_mode;
endsequence
sequence s_pdn_clr;
    reg_wr && reg_addr == 8'h0A && !reg_wdata[1] && reg_wdata[4] && low_power;
endsequence
chk_boot_mode: assert property (s_boot |-> fuse_mode == $past(mode_strap_in, 22))
    else $error("mode not taken from strap at start-up");
chk_bus_page0: assert property (s_boot ##0 !fuse_mode |-> !spread_enable && spread_setting == 3'h0)
    else $error("bus mode did not start from page 0");
chk_mode_held: assert property ((!fuse_mode && !low_power && config_stable)[*2] |=> !fuse_mode)
    else $error("mode followed live strap");
chk_fuse_bus_off: assert property (fuse_mode |-> !bus_enable && bus_target_addr == 7'h00)
    else $error("bus active in fuse mode");
chk_fuse_rd_zero: assert property (reg_rd && fuse_mode && $past(fuse_mode) && config_stable |=> reg_rdata == 16'h0000)
    else $error("register read served in fuse mode");
chk_id_flag: assert property (reg_rd && reg_addr == 8'h00 && !fuse_mode && config_stable |=> reg_rdata[0])
    else $error("fuse programmed flag not set");
chk_page_fields: assert property ((fuse_mode && config_stable && $stable(active_page))[*4]
    |-> spread_enable == active_page[0] && spread_setting == {1'b0, active_page[1], ^active_page})
    else $error("page fields do not match active page");
chk_lp_entry: assert property (s_pdn_set |-> ##3 low_power)
    else $error("power down write not obeyed");
chk_lp_exit: assert property (s_pdn_clr |-> ##[1:4] !low_power)
    else $error("power down clear not obeyed");
chk_switch_wait: assert property (fuse_mode |-> unstable_cnt_reg <= SWITCH_WIN_CYC + 18'h8)
    else $error("page switch window overrun");
chk_reload_time: assert property (unstable_cnt_reg <= SWITCH_WIN_CYC + 18'h28)
    else $error("reload did not settle in time");
endmodule

// *** mscc_strap_board.sv ***
`timescale 1ns/100ps
module mscc_strap_board
(
    input  wire       mclk,
    input  wire [4:0] want,
    output reg        mode_strap_in,
    output reg        page_select_bit1,
    output reg        page_select_bit0,
    output reg  [1:0] addr_strap_in
);
// Levels move only on request; a new mode is taken at power-up, low-power exit or switch-window expiry
always @(posedge mclk)
begin
    {mode_strap_in, page_select_bit1, page_select_bit0, addr_strap_in} <= want;
end
endmodule

// *** mscc_config_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "mscc_defines.vh"
module mscc_config_ctrl_tb;
reg         mclk, srst, reg_wr, reg_rd;
reg  [4:0]  want;
reg  [7:0]  reg_addr;
reg  [15:0] reg_wdata;
wire        mode_strap_in, page_select_bit0, page_select_bit1;
wire [1:0]  addr_strap_in, active_page;
wire [15:0] reg_rdata;
wire [6:0]  bus_target_addr;
wire [2:0]  spread_setting;
wire        fuse_mode, bus_enable, low_power, config_stable, spread_enable;
wire        pair_ab_enable, pair_cd_enable;
wire [1:0]  pair_ab_format, pair_cd_format;
integer     fails, n_tests, cyc, i;
mscc_strap_board board (.mclk(mclk), .want(want), .mode_strap_in(mode_strap_in),
    .page_select_bit1(page_select_bit1), .page_select_bit0(page_select_bit0), .addr_strap_in(addr_strap_in));
mscc_config_ctrl #(.SWITCH_WIN_CYC(17'h14)) uut (.mclk(mclk), .srst(srst),
    .mode_strap_in(mode_strap_in), .page_select_bit0(page_select_bit0),
    .page_select_bit1(page_select_bit1), .addr_strap_in(addr_strap_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fuse_mode(fuse_mode), .bus_enable(bus_enable), .bus_target_addr(bus_target_addr),
    .active_page(active_page), .low_power(low_power), .config_stable(config_stable),
    .spread_enable(spread_enable), .spread_setting(spread_setting), .pair_ab_enable(pair_ab_enable),
    .pair_cd_enable(pair_cd_enable), .pair_ab_format(pair_ab_format), .pair_cd_format(pair_cd_format));
// ------------------------------------------------------------
// Shared tasks
// ------------------------------------------------------------
task cmp(input [15:0] got, input [15:0] exp);
begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task wt(input integer n);
begin
    repeat (n) @(posedge mclk);
    #1;
end
endtask
task por(input [4:0] w);
begin
    @(posedge mclk);
    want <= w;
    srst <= 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    wt(24);
end
endtask
task wr(input [7:0] a, input [15:0] d);
begin
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
end
endtask
task rd(input [7:0] a, input [15:0] exp);
begin
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
end
endtask
task stop_test;
begin
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
end
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task t_pages;
begin
    for (i = 0; i < 4; i = i + 1)
    begin
        por({1'b1, i[1:0], 2'b00});
        cmp(fuse_mode, 1);
        cmp(bus_enable, 0);
        cmp(active_page, i);
        cmp(spread_enable, (`MSCC_PG_SPREAD_EN >> i) & 1);
        cmp(spread_setting, (`MSCC_PG_SPREAD_SET >> (3 * i)) & 7);
        cmp(pair_ab_enable, (`MSCC_PG_AB_EN >> i) & 1);
        cmp(pair_cd_format, (`MSCC_PG_CD_FMT >> (2 * i)) & 3);
        cmp(config_stable, 1);
        rd(8'h00, 16'h0000);
    end
    $display("pages done");
end
endtask
task t_switch;
begin
    @(posedge mclk);
    want <= 5'b10100;
    wt(40);
    cmp(active_page, 1);
    cmp(spread_setting, (`MSCC_PG_SPREAD_SET >> 3) & 7);
    @(posedge mclk);
    want <= 5'b01100;
    wt(60);
    cmp(fuse_mode, 0);
    cmp(bus_enable, 1);
    cmp(active_page, 0);
    $display("switch done");
end
endtask
task t_bus;
begin
    for (i = 0; i < 4; i = i + 1)
    begin
        por({3'b000, i[1:0]});
        cmp(fuse_mode, 0);
        cmp(bus_target_addr, 7'h68 + i);
        cmp(spread_setting, 0);
    end
    rd(8'h00, 16'h0001);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h0001);
    rd(8'h20, 16'h0000);
    @(posedge mclk);
    want <= 5'b10011;
    wt(8);
    cmp(fuse_mode, 0);
    @(posedge mclk);
    want <= 5'b00011;
    wr(8'h0C, 16'h5500);
    wt(3);
    cmp(bus_target_addr, 7'h55);
    wr(8'h0C, 16'hA800);
    wt(3);
    cmp(bus_target_addr, 7'h2B);
    $display("bus done");
end
endtask
task t_lp;
begin
    por(5'b00000);
    wr(8'h0A, 16'h0002);
    wt(3);
    cmp(low_power, 1);
    wr(8'h04, 16'h0001);
    wr(8'h0B, 16'h0037);
    wr(8'h0A, 16'h001C);
    wt(30);
    cmp(low_power, 0);
    cmp(spread_enable, 1);
    cmp(pair_ab_format, 1);
    cmp(pair_cd_format, 3);
    wr(8'h0A, 16'h001A);
    wt(3);
    cmp(low_power, 1);
    wr(8'h0A, 16'h0018);
    wt(30);
    cmp(spread_enable, 0);
    cmp(pair_cd_format, 0);
    wr(8'h0A, 16'h0006);
    wr(8'h04, 16'h0001);
    wr(8'h0A, 16'h0014);
    wt(30);
    cmp(low_power, 0);
    cmp(spread_enable, 1);
    wr(8'h0A, 16'h0000);
    wr(8'h0B, 16'h0000);
    wt(3);
    cmp(low_power, 1);
    cmp(pair_ab_enable, 0);
    @(posedge mclk);
    want <= 5'b11100;
    wr(8'h0B, 16'h0003);
    wt(30);
    cmp(fuse_mode, 1);
    cmp(active_page, 3);
    $display("low power done");
end
endtask
// ------------------------------------------------------------
// Clock, watchdog and main sequence
// ------------------------------------------------------------
initial
begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
end
always @(posedge mclk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        fails = fails + 1;
        $display("ERROR %0t: timeout", $time);
        stop_test;
    end
end
initial
begin
    fails = 0;
    n_tests = 0;
    cyc = 0;
    srst = 1'b1;
    want = 5'b00000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    t_pages;
    t_switch;
    t_bus;
    t_lp;
    stop_test;
end
endmodule
bind mscc_config_ctrl mscc_config_ctrl_asserts #(.SWITCH_WIN_CYC(SWITCH_WIN_CYC)) u_chk (.mclk(mclk),
    .srst(srst), .mode_strap_in(mode_strap_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_mode(fuse_mode),
    .bus_enable(bus_enable), .bus_target_addr(bus_target_addr), .active_page(active_page),
    .low_power(low_power), .config_stable(config_stable), .spread_enable(spread_enable),
    .spread_setting(spread_setting));
